// ### src/gpb_port.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module gpb_port (
	input  wire logic                          I_SYS_CLK,
	input  wire logic                          I_RESET,
	input  wire logic                          I_POWER_ON,
	input  wire logic                          I_PSEL,
	input  wire logic                          I_PENABLE,
	input  wire logic                          I_PWRITE,
	input  wire logic [gpb_pkg::ADDR_W-1:0]    I_PADDR,
	input  wire logic [gpb_pkg::DATA_W-1:0]    I_PWDATA,
	input  wire logic [3:0]                    I_PSTRB,
	output logic                               O_PREADY,
	output logic      [gpb_pkg::DATA_W-1:0]    O_PRDATA,
	output logic                               O_PSLVERR,
	input  wire logic [gpb_pkg::PORT_W-1:0]    I_PIN,
	output logic      [gpb_pkg::PORT_W-1:0]    O_PIN_OUT,
	output logic      [gpb_pkg::PORT_W-1:0]    O_PIN_OE,
	output logic      [gpb_pkg::PORT_W-1:0]    O_PULLUP_EN,
	output logic      [gpb_pkg::PORT_W-1:0]    O_SCHMITT_SEL,
	input  wire logic                          I_PROG_MODE,
	input  wire logic                          I_PROG_DATA_OUT,
	input  wire logic                          I_PROG_DATA_OE,
	output logic                               O_PROG_CLK,
	output logic                               O_PROG_DATA,
	output logic                               O_IRQ
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [gpb_pkg::PORT_W-1:0]   second_port_data;
	logic [gpb_pkg::PORT_W-1:0]   second_port_direction;
	logic [gpb_pkg::PORT_W-1:0]   timer_and_port_options;
	logic [gpb_pkg::PORT_W-1:0]   port_ctrl;
	logic [gpb_pkg::PORT_W-1:0]   level;
	logic [gpb_pkg::PORT_W-1:0]   read_view;
	logic [gpb_pkg::PORT_W-1:0]   override;
	logic [gpb_pkg::PORT_W-1:0]   override_out;
	logic [gpb_pkg::PORT_W-1:0]   override_oe;
	logic [gpb_pkg::CHANGE_W-1:0] change_ref;
	logic [gpb_pkg::CHANGE_W-1:0] change_diff;
	logic [gpb_pkg::IRQ_W-1:0]    irq_event;
	logic [gpb_pkg::IRQ_W-1:0]    irq_status;
	logic [gpb_pkg::IRQ_W-1:0]    irq_enable;
	logic [gpb_pkg::IDX_W-1:0]    idx;
	logic [gpb_pkg::DATA_W-1:0]   next_prdata;
	logic                         next_pslverr;
	logic                         pullup_disable_n;
	logic                         ext_interrupt_edge_select;
	logic                         ext_source_en;
	logic                         pin0_prev;
	logic                         rise0;
	logic                         fall0;
	logic                         ext_event;
	logic                         change_event;
	logic                         setup_phase;
	logic                         access_phase;
	logic                         wr_ok;
	logic                         rd_ok;
	logic                         addr_ok;
	logic                         wr_data;
	logic                         wr_dir;
	logic                         wr_option;
	logic                         wr_ctrl;
	logic                         wr_clear;
	logic                         wr_enable;
	logic                         rd_data;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign idx          = I_PADDR[gpb_pkg::IDX_W+1:2];
	assign setup_phase  = I_PSEL & ~I_PENABLE;
	assign access_phase = I_PSEL & I_PENABLE;
	// Only the low byte lane carries register bits
	assign wr_ok        = access_phase & I_PWRITE & I_PSTRB[0] & addr_ok;
	assign rd_ok        = access_phase & ~I_PWRITE & addr_ok;
	assign wr_data      = wr_ok & (idx == gpb_pkg::IDX_DATA);
	assign wr_dir       = wr_ok & (idx == gpb_pkg::IDX_DIR);
	assign wr_option    = wr_ok & (idx == gpb_pkg::IDX_OPTION);
	assign wr_ctrl      = wr_ok & (idx == gpb_pkg::IDX_CTRL);
	assign wr_clear     = wr_ok & (idx == gpb_pkg::IDX_CLEAR);
	assign wr_enable    = wr_ok & (idx == gpb_pkg::IDX_ENABLE);
	assign rd_data      = rd_ok & (idx == gpb_pkg::IDX_DATA);

	always_comb begin
		addr_ok = 1'b0;
		if (I_PADDR[1:0] == 2'h0 && I_PADDR[gpb_pkg::ADDR_W-1:gpb_pkg::IDX_W+2] == 2'h0) begin
			case (idx)
				gpb_pkg::IDX_DATA,
				gpb_pkg::IDX_DIR,
				gpb_pkg::IDX_OPTION,
				gpb_pkg::IDX_STATUS,
				gpb_pkg::IDX_CLEAR,
				gpb_pkg::IDX_ENABLE,
				gpb_pkg::IDX_CTRL: begin
					addr_ok = 1'b1;
				end
				default: begin
					addr_ok = 1'b0;
				end
			endcase
		end
	end

	// Write-only clear register reads as zero
	always_comb begin
		next_prdata = '0;
		case (idx)
			gpb_pkg::IDX_DATA: begin
				next_prdata[gpb_pkg::PORT_W-1:0] = read_view;
			end
			gpb_pkg::IDX_DIR: begin
				next_prdata[gpb_pkg::PORT_W-1:0] = second_port_direction;
			end
			gpb_pkg::IDX_OPTION: begin
				next_prdata[gpb_pkg::PORT_W-1:0] = timer_and_port_options;
			end
			gpb_pkg::IDX_STATUS: begin
				next_prdata[gpb_pkg::IRQ_W-1:0] = irq_status;
			end
			gpb_pkg::IDX_ENABLE: begin
				next_prdata[gpb_pkg::IRQ_W-1:0] = irq_enable;
			end
			gpb_pkg::IDX_CTRL: begin
				next_prdata[gpb_pkg::PORT_W-1:0] = port_ctrl;
			end
			default: begin
				next_prdata = '0;
			end
		endcase
	end

	assign next_pslverr = ~addr_ok;
	// Zero wait states: read data is caught in the setup cycle
	assign O_PREADY     = 1'b1;

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			O_PRDATA  <= '0;
			O_PSLVERR <= 1'b0;
		end else if (setup_phase) begin
			O_PRDATA  <= next_prdata;
			O_PSLVERR <= next_pslverr;
		end
	end

	// ----------------------------------------
	// Port registers
	// ----------------------------------------
	// Only power-on gives a value, other resets keep the latch
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			if (I_POWER_ON) begin
				second_port_data <= gpb_pkg::POR_DATA;
			end
		end else if (wr_data) begin
			second_port_data <= I_PWDATA[gpb_pkg::PORT_W-1:0];
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			second_port_direction <= gpb_pkg::RST_DIR;
		end else if (wr_dir) begin
			second_port_direction <= I_PWDATA[gpb_pkg::PORT_W-1:0];
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			timer_and_port_options <= gpb_pkg::RST_OPTION;
		end else if (wr_option) begin
			timer_and_port_options <= I_PWDATA[gpb_pkg::PORT_W-1:0];
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			port_ctrl <= gpb_pkg::RST_CTRL;
		end else if (wr_ctrl) begin
			port_ctrl <= I_PWDATA[gpb_pkg::PORT_W-1:0];
		end
	end

	assign pullup_disable_n          = timer_and_port_options[gpb_pkg::OPT_PULLUP_N_BIT];
	assign ext_interrupt_edge_select = timer_and_port_options[gpb_pkg::OPT_EDGE_BIT];
	assign ext_source_en             = port_ctrl[gpb_pkg::CTRL_EXT_BIT];

	// Output pins read back their own latch, inputs read the pad
	assign read_view = (level & second_port_direction) | (second_port_data & ~second_port_direction);

	// ----------------------------------------
	// Pin cells
	// ----------------------------------------
	always_comb begin
		override                             = '0;
		override_out                         = '0;
		override_oe                          = '0;
		override[gpb_pkg::PIN_PROG_CLK]      = I_PROG_MODE;
		override[gpb_pkg::PIN_PROG_DATA]     = I_PROG_MODE;
		override_out[gpb_pkg::PIN_PROG_DATA] = I_PROG_DATA_OUT;
		override_oe[gpb_pkg::PIN_PROG_DATA]  = I_PROG_DATA_OE;
	end

	for (genvar n = 0; n < gpb_pkg::PORT_W; n++) begin : g_pin
		gpb_pin u_pin (
			.i_clk              (I_SYS_CLK),
			.i_reset            (I_RESET),
			.i_dir              (second_port_direction[n]),
			.i_data             (second_port_data[n]),
			.i_pullup_disable_n (pullup_disable_n),
			.i_pin              (I_PIN[n]),
			.i_override         (override[n]),
			.i_override_out     (override_out[n]),
			.i_override_oe      (override_oe[n]),
			.o_pin_out          (O_PIN_OUT[n]),
			.o_pin_oe           (O_PIN_OE[n]),
			.o_pullup_en        (O_PULLUP_EN[n]),
			.o_level            (level[n])
		);
	end

	assign O_PROG_CLK  = level[gpb_pkg::PIN_PROG_CLK];
	assign O_PROG_DATA = level[gpb_pkg::PIN_PROG_DATA];

	// ----------------------------------------
	// Input buffer selection
	// ----------------------------------------
	always_comb begin
		O_SCHMITT_SEL                        = '0;
		O_SCHMITT_SEL[gpb_pkg::PIN_EXT]      = ext_source_en;
		O_SCHMITT_SEL[gpb_pkg::PIN_PROG_CLK] = I_PROG_MODE;
		O_SCHMITT_SEL[gpb_pkg::PIN_PROG_DATA] = I_PROG_MODE;
	end

	// ----------------------------------------
	// External interrupt edge
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			pin0_prev <= 1'b0;
		end else begin
			pin0_prev <= level[gpb_pkg::PIN_EXT];
		end
	end

	assign rise0     = level[gpb_pkg::PIN_EXT] & ~pin0_prev;
	assign fall0     = ~level[gpb_pkg::PIN_EXT] & pin0_prev;
	assign ext_event = ext_source_en & (ext_interrupt_edge_select ? rise0 : fall0);

	// ----------------------------------------
	// Change detect
	// ----------------------------------------
	// Mismatch keeps setting the flag until software reads the port
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RESET) begin
			change_ref <= '0;
		end else if (rd_data) begin
			change_ref <= level[gpb_pkg::CHANGE_LO +: gpb_pkg::CHANGE_W];
		end
	end

	assign change_diff  = (level[gpb_pkg::CHANGE_LO +: gpb_pkg::CHANGE_W] ^ change_ref)
		& second_port_direction[gpb_pkg::CHANGE_LO +: gpb_pkg::CHANGE_W];
	assign change_event = |change_diff;

	always_comb begin
		irq_event                          = '0;
		irq_event[gpb_pkg::IRQ_EXT_BIT]    = ext_event;
		irq_event[gpb_pkg::IRQ_CHANGE_BIT] = change_event;
	end

	// ----------------------------------------
	// Interrupt registers
	// ----------------------------------------
	gpb_intr u_intr (
		.i_clk       (I_SYS_CLK),
		.i_reset     (I_RESET),
		.i_event     (irq_event),
		.i_clear_wr  (wr_clear),
		.i_enable_wr (wr_enable),
		.i_wdata     (I_PWDATA[gpb_pkg::IRQ_W-1:0]),
		.o_status    (irq_status),
		.o_enable    (irq_enable),
		.o_irq       (O_IRQ)
	);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RESET);

	property p_reset_ones;
		$past(I_RESET) |-> (second_port_direction == 8'hFF) && (timer_and_port_options == 8'hFF);
	endproperty
	a_reset_ones: assert property (p_reset_ones) else $error("direction or options not all ones after reset");

	property p_data_kept;
		@(posedge I_SYS_CLK) disable iff (1'b0)
		(I_RESET && !I_POWER_ON) |=> (second_port_data == $past(second_port_data));
	endproperty
	a_data_kept: assert property (p_data_kept) else $error("data latch changed by a non power-on reset");

	property p_dir_drive;
		!I_PROG_MODE |-> (O_PIN_OE == ~second_port_direction) && (O_PIN_OUT == second_port_data);
	endproperty
	a_dir_drive: assert property (p_dir_drive) else $error("pin drive does not follow direction and data");

	property p_pullup;
		O_PULLUP_EN == (second_port_direction & {8{~pullup_disable_n}});
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up enable wrong");

	property p_buffer_sel;
		(O_SCHMITT_SEL[5:1] == 5'h00) && (O_SCHMITT_SEL[0] == ext_source_en)
		&& (O_SCHMITT_SEL[7:6] == {2{I_PROG_MODE}});
	endproperty
	a_buffer_sel: assert property (p_buffer_sel) else $error("input buffer selection wrong");

	property p_prog_pins;
		I_PROG_MODE |-> !O_PIN_OE[6] && (O_PIN_OE[7] == I_PROG_DATA_OE);
	endproperty
	a_prog_pins: assert property (p_prog_pins) else $error("programming pins driven wrongly");

	property p_prog_rx;
		$rose(I_PIN[6]) |=> O_PROG_CLK;
	endproperty
	a_prog_rx: assert property (p_prog_rx) else $error("programming clock not received");

	property p_ext_edge;
		(ext_source_en && ext_interrupt_edge_select && $rose(level[0])) |=> irq_status[0];
	endproperty
	a_ext_edge: assert property (p_ext_edge) else $error("rising edge on pin 0 missed");

	property p_ext_quiet;
		!ext_source_en && !irq_status[0] |=> !irq_status[0];
	endproperty
	a_ext_quiet: assert property (p_ext_quiet) else $error("external flag set while source disabled");

	property p_change;
		(second_port_direction[7:4] != 4'h0) && $changed(level[7:4])
		&& ((level[7:4] ^ change_ref) & second_port_direction[7:4]) != 4'h0 |=> irq_status[1];
	endproperty
	a_change: assert property (p_change) else $error("port change not flagged");

	property p_read_latch;
		rd_data |=> (change_ref == $past(level[7:4]));
	endproperty
	a_read_latch: assert property (p_read_latch) else $error("change reference not latched on read");

	property p_irq;
		(irq_status & irq_enable) != 2'h0 |-> O_IRQ ##1 (O_IRQ || $past(wr_clear) || $past(wr_enable));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt output dropped without clear");

	c_ext: cover property (ext_event ##1 O_IRQ);
	c_change: cover property (change_event ##1 irq_status[1]);
	c_prog: cover property (I_PROG_MODE ##1 $rose(O_PROG_CLK));
	c_read: cover property (rd_data);
endmodule : gpb_port

// ### src/gpb_pkg.sv
package gpb_pkg;
	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned IDX_W  = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned PORT_W = 8;
	localparam int unsigned IRQ_W  = 2;

	// ----------------------------------------
	// Register indexes, byte address is four times
	// ----------------------------------------
	localparam logic [IDX_W-1:0] IDX_DATA   = 8'h06;
	localparam logic [IDX_W-1:0] IDX_OPTION = 8'h81;
	localparam logic [IDX_W-1:0] IDX_DIR    = 8'h86;
	localparam logic [IDX_W-1:0] IDX_STATUS = 8'h10;
	localparam logic [IDX_W-1:0] IDX_CLEAR  = 8'h11;
	localparam logic [IDX_W-1:0] IDX_ENABLE = 8'h12;
	localparam logic [IDX_W-1:0] IDX_CTRL   = 8'h13;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int unsigned OPT_PULLUP_N_BIT = 7;
	localparam int unsigned OPT_EDGE_BIT     = 6;
	localparam int unsigned CTRL_EXT_BIT     = 0;
	localparam int unsigned IRQ_EXT_BIT      = 0;
	localparam int unsigned IRQ_CHANGE_BIT   = 1;
	localparam int unsigned PIN_EXT          = 0;
	localparam int unsigned PIN_PROG_CLK     = 6;
	localparam int unsigned PIN_PROG_DATA    = 7;
	localparam int unsigned CHANGE_LO        = 4;
	localparam int unsigned CHANGE_W         = 4;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [PORT_W-1:0] RST_DIR    = 8'hFF;
	localparam logic [PORT_W-1:0] RST_OPTION = 8'hFF;
	localparam logic [PORT_W-1:0] POR_DATA   = 8'h00;
	localparam logic [PORT_W-1:0] RST_CTRL   = 8'h00;
	localparam logic [IRQ_W-1:0]  RST_IRQ    = 2'h0;
	localparam logic [PORT_W-1:0] RST_LEVEL  = 8'h00;
endpackage : gpb_pkg

// ### src/gpb_pin.sv
`timescale 1ns/1ps
module gpb_pin (
	input  wire logic i_clk,
	input  wire logic i_reset,
	input  wire logic i_dir,
	input  wire logic i_data,
	input  wire logic i_pullup_disable_n,
	input  wire logic i_pin,
	input  wire logic i_override,
	input  wire logic i_override_out,
	input  wire logic i_override_oe,
	output logic      o_pin_out,
	output logic      o_pin_oe,
	output logic      o_pullup_en,
	output logic      o_level
);
	// ----------------------------------------
	// Pad drive, direction bit set means input
	// ----------------------------------------
	assign o_pin_out   = i_override ? i_override_out : i_data;
	assign o_pin_oe    = i_override ? i_override_oe : ~i_dir;
	assign o_pullup_en = i_dir & ~i_pullup_disable_n;

	// ----------------------------------------
	// Input sample
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_level <= 1'b0;
		end else begin
			o_level <= i_pin;
		end
	end
endmodule : gpb_pin

// ### src/gpb_intr.sv
`timescale 1ns/1ps
module gpb_intr (
	input  wire logic                        i_clk,
	input  wire logic                        i_reset,
	input  wire logic [gpb_pkg::IRQ_W-1:0]   i_event,
	input  wire logic                        i_clear_wr,
	input  wire logic                        i_enable_wr,
	input  wire logic [gpb_pkg::IRQ_W-1:0]   i_wdata,
	output logic      [gpb_pkg::IRQ_W-1:0]   o_status,
	output logic      [gpb_pkg::IRQ_W-1:0]   o_enable,
	output logic                             o_irq
);
	logic [gpb_pkg::IRQ_W-1:0] next_status;

	// ----------------------------------------
	// Sticky status, set wins over clear
	// ----------------------------------------
	always_comb begin
		next_status = o_status;
		if (i_clear_wr) begin
			next_status = next_status & ~i_wdata;
		end
		next_status = next_status | i_event;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_status <= gpb_pkg::RST_IRQ;
		end else begin
			o_status <= next_status;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_enable <= gpb_pkg::RST_IRQ;
		end else if (i_enable_wr) begin
			o_enable <= i_wdata;
		end
	end

	assign o_irq = |(o_status & o_enable);
endmodule : gpb_intr

// ### bench/gpb_pads.sv
`timescale 1ns/1ps
// ----------------------------------------
// Pad ring and serial programmer
// ----------------------------------------
module gpb_pads (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_ext_val,
	input  wire logic [7:0] i_ext_oe,
	input  wire logic       i_prog_active,
	input  wire logic       i_prog_clk,
	input  wire logic       i_prog_data,
	input  wire logic [7:0] i_dev_out,
	input  wire logic [7:0] i_dev_oe,
	input  wire logic [7:0] i_pullup_en,
	output logic      [7:0] o_pin
);
	logic [7:0] drv_val;
	logic [7:0] drv_oe;
	logic [7:0] last = 8'h00;
	always_comb begin
		drv_val = i_ext_val;
		drv_oe  = i_ext_oe;
		if (i_prog_active) begin
			drv_val[6] = i_prog_clk;
			drv_oe[6]  = 1'h1;
			drv_val[7] = i_prog_data;
			drv_oe[7]  = ~i_dev_oe[7];
		end
	end
	// Undriven pin without pull-up toggles, so no stale level can pass
	always_comb begin
		for (int b = 0; b < 8; b++) begin
			if (i_dev_oe[b])
				o_pin[b] = i_dev_out[b];
			else if (drv_oe[b])
				o_pin[b] = drv_val[b];
			else if (i_pullup_en[b])
				o_pin[b] = 1'h1;
			else
				o_pin[b] = ~last[b];
		end
	end
	// Plain always, the start value comes from the declaration
	always @(posedge i_clk) begin
		last <= o_pin;
	end
endmodule : gpb_pads

// ### bench/gpb_port_bench.sv
`timescale 1ns/1ps
module gpb_port_bench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        por = 1'h1;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [7:0]  pin, pin_out, pin_oe, pullup_en, schmitt;
	logic        prog_mode = 1'h0;
	logic        pdo = 1'h0;
	logic        pdoe = 1'h0;
	logic        prog_clk_o, prog_data_o, irq;
	logic [7:0]  ext_val = 8'h00;
	logic [7:0]  ext_oe = 8'hFF;
	logic        pgm_clk = 1'h0;
	logic        pgm_data = 1'h0;
	int          err_total = 0;
	int          comparisons = 0;
	logic [31:0] rd;
	logic        er;

	always #5 clk = ~clk;

	gpb_port DUT (.I_SYS_CLK(clk), .I_RESET(rst), .I_POWER_ON(por), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PREADY(pready),
		.O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_PIN(pin), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe),
		.O_PULLUP_EN(pullup_en), .O_SCHMITT_SEL(schmitt), .I_PROG_MODE(prog_mode), .I_PROG_DATA_OUT(pdo),
		.I_PROG_DATA_OE(pdoe), .O_PROG_CLK(prog_clk_o), .O_PROG_DATA(prog_data_o), .O_IRQ(irq));

	gpb_pads pads (.i_clk(clk), .i_ext_val(ext_val), .i_ext_oe(ext_oe), .i_prog_active(prog_mode),
		.i_prog_clk(pgm_clk), .i_prog_data(pgm_data), .i_dev_out(pin_out), .i_dev_oe(pin_oe),
		.i_pullup_en(pullup_en), .o_pin(pin));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic report_and_stop;
		if (err_total == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	// Extra edge at the end lets the write land before callers look at pads
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] strb);
		int n;
		@(posedge clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= {2'h0, idx, 2'h0};
		pwdata  <= {24'h0, d};
		pstrb   <= strb;
		@(posedge clk);
		penable <= 1'h1;
		for (n = 0; n < 32; n++) begin
			@(posedge clk);
			if (pready === 1'h1)
				break;
		end
		if (n == 32)
			err_total++;
		rd = prdata;
		er = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'h1, idx, d, 4'hF);
	endtask : wr

	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'h0, idx, 8'h00, 4'hF);
		chk(rd, exp);
	endtask : rdc

	task automatic rst_dut(input logic po);
		@(posedge clk);
		rst <= 1'h1;
		por <= po;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		por <= 1'h0;
	endtask : rst_dut

	task automatic pins(input logic [7:0] oe, input logic [7:0] v);
		@(posedge clk);
		ext_oe  <= oe;
		ext_val <= v;
		repeat (4) @(posedge clk);
	endtask : pins

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		report_and_stop;
	end

	initial begin
		rst_dut(1'h1);
		rdc(gpb_pkg::IDX_OPTION, 32'hFF);
		rdc(gpb_pkg::IDX_DIR, 32'hFF);
		chk(32'(pin_oe), 32'h0);
		chk(32'(pullup_en), 32'h0);
		wr(gpb_pkg::IDX_DIR, 8'h00);
		rdc(gpb_pkg::IDX_DATA, 32'(gpb_pkg::POR_DATA));
		wr(gpb_pkg::IDX_DATA, 8'hA5);
		chk(32'(pin_out), 32'hA5);
		rst_dut(1'h0);
		rdc(gpb_pkg::IDX_DIR, 32'hFF);
		wr(gpb_pkg::IDX_DIR, 8'h00);
		rdc(gpb_pkg::IDX_DATA, 32'hA5);
		rst_dut(1'h1);
		pins(8'hFF, 8'h09);
		wr(gpb_pkg::IDX_DIR, 8'h0F);
		wr(gpb_pkg::IDX_DATA, 8'h5A);
		chk(32'(pin_oe), 32'hF0);
		rdc(gpb_pkg::IDX_DATA, 32'h59);
		apb(1'h1, gpb_pkg::IDX_DATA, 8'hFF, 4'h0);
		rdc(gpb_pkg::IDX_DATA, 32'h59);
		// Pull-ups hold released input pins high
		wr(gpb_pkg::IDX_OPTION, 8'h7F);
		pins(8'h00, 8'h00);
		chk(32'(pullup_en), 32'h0F);
		rdc(gpb_pkg::IDX_DATA, 32'h5F);
		wr(gpb_pkg::IDX_OPTION, 8'hFF);
		chk(32'(pullup_en), 32'h0);
		apb(1'h0, 8'h20, 8'h00, 4'hF);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		// External interrupt on pin 0, both edge selections
		pins(8'hFF, 8'h00);
		wr(gpb_pkg::IDX_DIR, 8'hFF);
		rdc(gpb_pkg::IDX_DATA, 32'h00);
		wr(gpb_pkg::IDX_CTRL, 8'h01);
		chk(32'(schmitt), 32'h01);
		wr(gpb_pkg::IDX_ENABLE, 8'h01);
		wr(gpb_pkg::IDX_CLEAR, 8'h03);
		pins(8'hFF, 8'h01);
		rdc(gpb_pkg::IDX_STATUS, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(gpb_pkg::IDX_CLEAR, 8'h01);
		chk({31'h0, irq}, 32'h0);
		pins(8'hFF, 8'h00);
		rdc(gpb_pkg::IDX_STATUS, 32'h0);
		wr(gpb_pkg::IDX_OPTION, 8'hBF);
		pins(8'hFF, 8'h01);
		rdc(gpb_pkg::IDX_STATUS, 32'h0);
		pins(8'hFF, 8'h00);
		rdc(gpb_pkg::IDX_STATUS, 32'h1);
		wr(gpb_pkg::IDX_ENABLE, 8'h00);
		chk({31'h0, irq}, 32'h0);
		wr(gpb_pkg::IDX_CLEAR, 8'h01);
		wr(gpb_pkg::IDX_CTRL, 8'h00);
		chk(32'(schmitt), 32'h00);
		pins(8'hFF, 8'h01);
		pins(8'hFF, 8'h00);
		rdc(gpb_pkg::IDX_STATUS, 32'h0);
		// Change detect on pins 4 to 7 only
		pins(8'hFF, 8'h04);
		rdc(gpb_pkg::IDX_STATUS, 32'h0);
		pins(8'hFF, 8'h24);
		rdc(gpb_pkg::IDX_STATUS, 32'h2);
		wr(gpb_pkg::IDX_ENABLE, 8'h02);
		chk({31'h0, irq}, 32'h1);
		wr(gpb_pkg::IDX_CLEAR, 8'h02);
		rdc(gpb_pkg::IDX_STATUS, 32'h2);
		rdc(gpb_pkg::IDX_DATA, 32'h24);
		wr(gpb_pkg::IDX_CLEAR, 8'h02);
		rdc(gpb_pkg::IDX_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(gpb_pkg::IDX_DIR, 8'h0F);
		rdc(gpb_pkg::IDX_STATUS, 32'h0);
		wr(gpb_pkg::IDX_DIR, 8'hFF);
		// Serial programming through pins 6 and 7
		prog_mode <= 1'h1;
		pgm_clk   <= 1'h1;
		pgm_data  <= 1'h1;
		repeat (3) @(posedge clk);
		chk(32'(schmitt), 32'hC0);
		chk({30'h0, prog_clk_o, prog_data_o}, 32'h3);
		pgm_clk <= 1'h0;
		pdoe    <= 1'h1;
		pdo     <= 1'h1;
		repeat (3) @(posedge clk);
		chk({30'h0, prog_clk_o, prog_data_o}, 32'h1);
		chk({pin_oe, pin_out[7], 23'h0}, {8'h80, 1'h1, 23'h0});
		pdo <= 1'h0;
		repeat (3) @(posedge clk);
		chk({30'h0, prog_clk_o, prog_data_o}, 32'h0);
		chk({pin_oe, pin_out[7], 23'h0}, {8'h80, 24'h0});
		prog_mode <= 1'h0;
		pdoe      <= 1'h0;
		repeat (2) @(posedge clk);
		chk(32'(schmitt), 32'h00);
		report_and_stop;
	end
endmodule : gpb_port_bench
